//--- pkg/trip_pkg.sv
// constants shared by the overcurrent trip qualifier and its submodules
package trip_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int CUR_W = 12;
    localparam int DIV_W = 16;
    localparam int CNT_W = 8;
    localparam int PHASES = 3;
    localparam int CHANNELS = 2 * PHASES;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DIVIDER = 8'h08;
    localparam logic [7:0] OFS_WINDOW = 8'h0C;
    localparam logic [7:0] OFS_THRESH = 8'h10;
    localparam logic [7:0] OFS_LIMIT = 8'h14;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTL_CLEAR_BIT = 0;
    localparam int STS_TRIP_BIT = 0;
    localparam int STS_EXT_BIT = 1;
    localparam int STS_CMP_BIT = 2;
    localparam int LIM_POS_LSB = 0;
    localparam int LIM_NEG_LSB = 16;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam int CODES_PER_AMP = 64;
    localparam int TRIP_AMPS = 8;
    localparam logic [CUR_W-1:0] LIMIT_RST =
        CUR_W'(TRIP_AMPS * CODES_PER_AMP);
    localparam logic [DIV_W-1:0] DIVIDER_RST = 16'h0009;
    localparam logic [CNT_W-1:0] WINDOW_RST = 8'h08;
    localparam logic [CNT_W-1:0] THRESH_RST = 8'h05;

    // ------------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // zero is treated as one so a window or threshold never degenerates
    function automatic logic [CNT_W-1:0] at_least_one(
        input logic [CNT_W-1:0] v);
        at_least_one = (v == '0) ? CNT_W'(1) : v;
    endfunction : at_least_one

endpackage : trip_pkg

//--- core/level_comparator.sv
// digital window comparator for one sensed phase current
`timescale 1ns/1ps
`default_nettype none

module level_comparator #(
    parameter int W = trip_pkg::CUR_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sensed current and references
    input wire logic signed [W-1:0] current,
    input wire logic [W-1:0] pos_ref,
    input wire logic [W-1:0] neg_ref,
    // raw protection signals
    output logic raw_pos,
    output logic raw_neg
);

    logic signed [W:0] cur_x;
    logic signed [W:0] pos_x;
    logic signed [W:0] neg_x;

    assign cur_x = {current[W-1], current};
    assign pos_x = {1'b0, pos_ref};
    assign neg_x = -{1'b0, neg_ref};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_pos <= 1'b0;
            raw_neg <= 1'b0;
        end else begin
            raw_pos <= cur_x > pos_x;
            raw_neg <= cur_x < neg_x;
        end
    end

    AST_RAW_NEG: assert property (@(posedge aclk) disable iff (!aresetn)
        (cur_x < neg_x) |=> raw_neg)
        else $error("negative excursion did not raise raw signal");

endmodule : level_comparator

`default_nettype wire

//--- core/window_qualifier.sv
// counts sampled hits of one raw signal within a sample window
`timescale 1ns/1ps
`default_nettype none

module window_qualifier #(
    parameter int CW = trip_pkg::CNT_W
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sampling
    input wire logic sample_tick,
    input wire logic raw,
    input wire logic [CW-1:0] window_len,
    input wire logic [CW-1:0] threshold,
    // one-cycle pulse on qualification
    output logic qualified
);

    logic [CW-1:0] smp_cnt_r;
    logic [CW-1:0] hits_r;
    logic [CW-1:0] hits_nxt;
    logic [CW-1:0] win;
    logic [CW-1:0] thr;
    logic last;

    assign win = trip_pkg::at_least_one(window_len);
    assign thr = trip_pkg::at_least_one(threshold);
    assign hits_nxt = hits_r + CW'(raw);
    assign last = (smp_cnt_r + CW'(1)) >= win;

    // window bookkeeping; the window restarts after its last sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smp_cnt_r <= '0;
            hits_r <= '0;
        end else if (sample_tick) begin
            smp_cnt_r <= last ? '0 : smp_cnt_r + CW'(1);
            hits_r <= last ? '0 : hits_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qualified <= 1'b0;
        end else begin
            qualified <= sample_tick && raw && (hits_nxt >= thr);
        end
    end

    AST_QUAL_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
        qualified |-> $past(hits_r) + CW'(1) >= $past(thr))
        else $error("qualified with too few hits");

    AST_WIN_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(sample_tick) && $past(last) |-> smp_cnt_r == '0)
        else $error("sample window did not restart");

endmodule : window_qualifier

`default_nettype wire

//--- core/overcurrent_trip_qualifier.sv
// overcurrent trip path: comparators, qualifiers, trip latch, axi4-lite
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - separate positive and negative comparator references
// - raw signal asserts when current crosses reference
// - sample raw signals, count hits per window
// - sample rate from clock via programmable divider
// - window length in samples is programmable
// - programmable hit threshold qualifies overcurrent
// - one limit serves shunt and hall sensors
// - qualified overcurrent sets readable trip flag
// - writing one clears trip, pwm resumes
// - reset limit trips at eight amps
// - external shutdown input forces the trip
module overcurrent_trip_qualifier #(
    parameter int CW = trip_pkg::CUR_W,
    parameter logic PWM_INACTIVE = 1'b0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // sensed phase currents, phase a in the low bits
    input wire logic [trip_pkg::PHASES*CW-1:0] shunt_current,
    input wire logic [trip_pkg::PHASES*CW-1:0] hall_current,
    // external shutdown
    input wire logic ext_shutdown,
    // pwm from the generator
    input wire logic [trip_pkg::PHASES-1:0] pwm_high_in,
    input wire logic [trip_pkg::PHASES-1:0] pwm_low_in,
    // pwm to the inverter and trip status
    output logic [trip_pkg::PHASES-1:0] pwm_high_out,
    output logic [trip_pkg::PHASES-1:0] pwm_low_out,
    output logic overcurrent_trip_flag
);

    localparam int NCH = trip_pkg::CHANNELS;
    localparam int DW = trip_pkg::DIV_W;
    localparam int NW = trip_pkg::CNT_W;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [DW-1:0] filter_sample_divider_r;
    logic [NW-1:0] qualify_window_length_r;
    logic [NW-1:0] qualify_threshold_r;
    logic [CW-1:0] limit_pos_r;
    logic [CW-1:0] limit_neg_r;

    // ------------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    logic trip_clear_request;

    assign do_write = aw_held_r && w_held_r && !bvalid;
    assign trip_clear_request = do_write &&
        waddr_r == trip_pkg::OFS_CONTROL &&
        wstrb_r[0] && wdata_r[trip_pkg::CTL_CLEAR_BIT];

    // address and data are accepted in either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_held_r <= 1'b0;
            waddr_r <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held_r <= 1'b1;
            waddr_r <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_held_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= trip_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            unique case (waddr_r)
                trip_pkg::OFS_CONTROL, trip_pkg::OFS_STATUS,
                trip_pkg::OFS_DIVIDER, trip_pkg::OFS_WINDOW,
                trip_pkg::OFS_THRESH, trip_pkg::OFS_LIMIT:
                    bresp <= trip_pkg::RESP_OKAY;
                default: bresp <= trip_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // lanes are honoured per field; status is read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filter_sample_divider_r <= trip_pkg::DIVIDER_RST;
            qualify_window_length_r <= trip_pkg::WINDOW_RST;
            qualify_threshold_r <= trip_pkg::THRESH_RST;
            limit_pos_r <= trip_pkg::LIMIT_RST;
            limit_neg_r <= trip_pkg::LIMIT_RST;
        end else if (do_write) begin
            unique case (waddr_r)
                trip_pkg::OFS_DIVIDER: begin
                    if (wstrb_r[0]) begin
                        filter_sample_divider_r[7:0] <= wdata_r[7:0];
                    end
                    if (wstrb_r[1]) begin
                        filter_sample_divider_r[15:8] <= wdata_r[15:8];
                    end
                end
                trip_pkg::OFS_WINDOW: begin
                    if (wstrb_r[0]) qualify_window_length_r <= wdata_r[7:0];
                end
                trip_pkg::OFS_THRESH: begin
                    if (wstrb_r[0]) qualify_threshold_r <= wdata_r[7:0];
                end
                trip_pkg::OFS_LIMIT: begin
                    if (&wstrb_r[1:0]) begin
                        limit_pos_r <=
                            wdata_r[trip_pkg::LIM_POS_LSB +: CW];
                    end
                    if (&wstrb_r[3:2]) begin
                        limit_neg_r <=
                            wdata_r[trip_pkg::LIM_NEG_LSB +: CW];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    logic ext_cause_r;
    logic cmp_cause_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= trip_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= 32'h0000_0000;
            rresp <= trip_pkg::RESP_OKAY;
            unique case (araddr)
                trip_pkg::OFS_CONTROL: rdata <= 32'h0000_0000;
                trip_pkg::OFS_STATUS: begin
                    rdata[trip_pkg::STS_TRIP_BIT] <=
                        overcurrent_trip_flag;
                    rdata[trip_pkg::STS_EXT_BIT] <= ext_cause_r;
                    rdata[trip_pkg::STS_CMP_BIT] <= cmp_cause_r;
                end
                trip_pkg::OFS_DIVIDER: begin
                    rdata[DW-1:0] <= filter_sample_divider_r;
                end
                trip_pkg::OFS_WINDOW: rdata[NW-1:0] <= qualify_window_length_r;
                trip_pkg::OFS_THRESH: rdata[NW-1:0] <= qualify_threshold_r;
                trip_pkg::OFS_LIMIT: begin
                    rdata[trip_pkg::LIM_POS_LSB +: CW] <= limit_pos_r;
                    rdata[trip_pkg::LIM_NEG_LSB +: CW] <= limit_neg_r;
                end
                default: rresp <= trip_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // sample prescaler
    // ------------------------------------------------------------------
    logic [DW-1:0] div_cnt_r;
    logic sample_tick_r;

    // a tick every divider+1 clocks; divider zero samples every clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_r <= '0;
            sample_tick_r <= 1'b0;
        end else if (div_cnt_r >= filter_sample_divider_r) begin
            div_cnt_r <= '0;
            sample_tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + DW'(1);
            sample_tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // comparators and qualifiers, shunt channels first then hall
    // ------------------------------------------------------------------
    logic [NCH*CW-1:0] all_current;
    logic [NCH-1:0] raw_pos;
    logic [NCH-1:0] raw_neg;
    logic [NCH-1:0] qual_pos;
    logic [NCH-1:0] qual_neg;
    logic any_qualified;

    assign all_current = {hall_current, shunt_current};
    assign any_qualified = |{qual_pos, qual_neg};

    for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
        level_comparator #(.W(CW)) u_cmp (
            .aclk(aclk),
            .aresetn(aresetn),
            .current(all_current[ch*CW +: CW]),
            .pos_ref(limit_pos_r),
            .neg_ref(limit_neg_r),
            .raw_pos(raw_pos[ch]),
            .raw_neg(raw_neg[ch])
        );
        window_qualifier #(.CW(NW)) u_qpos (
            .aclk(aclk),
            .aresetn(aresetn),
            .sample_tick(sample_tick_r),
            .raw(raw_pos[ch]),
            .window_len(qualify_window_length_r),
            .threshold(qualify_threshold_r),
            .qualified(qual_pos[ch])
        );
        window_qualifier #(.CW(NW)) u_qneg (
            .aclk(aclk),
            .aresetn(aresetn),
            .sample_tick(sample_tick_r),
            .raw(raw_neg[ch]),
            .window_len(qualify_window_length_r),
            .threshold(qualify_threshold_r),
            .qualified(qual_neg[ch])
        );
    end

    // ------------------------------------------------------------------
    // trip latch and pwm gating
    // ------------------------------------------------------------------
    logic trip_set;
    logic trip_nxt;

    assign trip_set = any_qualified || ext_shutdown;
    // a new event in the clearing cycle wins over the clear
    assign trip_nxt = trip_set ||
        (overcurrent_trip_flag && !trip_clear_request);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overcurrent_trip_flag <= 1'b0;
        end else begin
            overcurrent_trip_flag <= trip_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_cause_r <= 1'b0;
            cmp_cause_r <= 1'b0;
        end else begin
            ext_cause_r <= ext_shutdown ||
                (ext_cause_r && !trip_clear_request);
            cmp_cause_r <= any_qualified ||
                (cmp_cause_r && !trip_clear_request);
        end
    end

    // gated on the next trip state so outputs drop with the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_high_out <= {trip_pkg::PHASES{PWM_INACTIVE}};
            pwm_low_out <= {trip_pkg::PHASES{PWM_INACTIVE}};
        end else if (trip_nxt) begin
            pwm_high_out <= {trip_pkg::PHASES{PWM_INACTIVE}};
            pwm_low_out <= {trip_pkg::PHASES{PWM_INACTIVE}};
        end else begin
            pwm_high_out <= pwm_high_in;
            pwm_low_out <= pwm_low_in;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_TRIP_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
        overcurrent_trip_flag && !trip_clear_request
        |=> overcurrent_trip_flag)
        else $error("trip flag dropped without clear");

    AST_PWM_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        overcurrent_trip_flag |-> (pwm_high_out ==
        {trip_pkg::PHASES{PWM_INACTIVE}} && pwm_low_out ==
        {trip_pkg::PHASES{PWM_INACTIVE}}))
        else $error("pwm active while tripped");

    AST_EXT_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_shutdown |=> overcurrent_trip_flag && ext_cause_r)
        else $error("external shutdown did not trip");

    AST_QUAL_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
        any_qualified |=> overcurrent_trip_flag && cmp_cause_r)
        else $error("qualified overcurrent did not trip");

    AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        trip_clear_request && !trip_set |=> !overcurrent_trip_flag)
        else $error("clear did not release trip");

    AST_RESUME: assert property (@(posedge aclk) disable iff (!aresetn)
        !overcurrent_trip_flag && $past(aresetn)
        |-> pwm_high_out == $past(pwm_high_in))
        else $error("pwm not resumed after clear");

    AST_TICK_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
        sample_tick_r && filter_sample_divider_r != '0
        && $stable(filter_sample_divider_r) |=> !sample_tick_r)
        else $error("sample ticks too close");

    AST_RST_LIMIT: assert property (@(posedge aclk)
        $rose(aresetn) |-> limit_pos_r == trip_pkg::LIMIT_RST
        && limit_neg_r == trip_pkg::LIMIT_RST)
        else $error("limit not at default after reset");

endmodule : overcurrent_trip_qualifier

`default_nettype wire

//--- testbench/inverter_model.sv
// sensed phase currents and pwm generator facing the trip qualifier
`timescale 1ns/1ps
`default_nettype none

module inverter_model (
    // clock
    input wire logic aclk,
    // commanded excursion on one channel
    input wire logic signed [11:0] level,
    input wire logic [1:0] phase,
    input wire logic on_hall,
    // sensor and pwm outputs
    output logic [35:0] shunt_current,
    output logic [35:0] hall_current,
    output logic [2:0] pwm_high,
    output logic [2:0] pwm_low
);
    integer seed = 26726;
    logic signed [11:0] noise;
    initial begin
        shunt_current = '0;
        hall_current = '0;
        pwm_high = '0;
        pwm_low = '0;
    end
    // small noise stays far below any limit the bench programs
    always @(posedge aclk) begin
        for (int i = 0; i < 3; i++) begin
            noise = 12'($random(seed) % 40);
            shunt_current[i*12 +: 12] <=
                (!on_hall && phase == i) ? level : noise;
            hall_current[i*12 +: 12] <=
                (on_hall && phase == i) ? level : noise;
        end
        pwm_high <= 3'($random(seed));
        pwm_low <= 3'($random(seed));
    end
endmodule : inverter_model

`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the overcurrent trip qualifier
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic aclk = 0, aresetn = 0;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0, ext_shutdown = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp, phase = '0;
    logic signed [11:0] level = '0;
    logic on_hall = 0, flag;
    logic [35:0] shunt_i, hall_i;
    logic [2:0] ph_in, pl_in, ph_out, pl_out, ph_prev, pl_prev;
    logic ok_prev = 0;
    logic [33:0] rd_q[$];
    logic [1:0] b_q[$];
    int fail_count = 0, n_checks = 0;

    initial forever #50 aclk = ~aclk;

    inverter_model model (.aclk(aclk), .level(level), .phase(phase),
        .on_hall(on_hall), .shunt_current(shunt_i), .hall_current(hall_i),
        .pwm_high(ph_in), .pwm_low(pl_in));

    overcurrent_trip_qualifier dut (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .shunt_current(shunt_i), .hall_current(hall_i),
        .ext_shutdown(ext_shutdown), .pwm_high_in(ph_in),
        .pwm_low_in(pl_in), .pwm_high_out(ph_out), .pwm_low_out(pl_out),
        .overcurrent_trip_flag(flag));

    task automatic check(input string what, input logic [33:0] e,
                         input logic [33:0] s);
        n_checks++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", what, e, s);
            fail_count++;
        end
    endtask : check

    task automatic end_of_test;
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // result watcher: bus answers and pwm gating
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (rvalid && rready)
            check("rdata", rd_q.pop_front(), {rresp, rdata});
        if (bvalid && bready) check("bresp", {32'h0, b_q.pop_front()},
                                    {32'h0, bresp});
        if (ok_prev && aresetn) begin
            if (flag === 1'b1)
                check("pwm_off", '0, {ph_out, pl_out});
            else
                check("pwm_pass", {ph_prev, pl_prev}, {ph_out, pl_out});
        end
        ph_prev = ph_in;
        pl_prev = pl_in;
        ok_prev = aresetn;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        b_q.push_back(r);
        awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d;
        wstrb <= 4'hF; bready <= 1; n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!(bvalid && bready) && n < 100);
        bready <= 0;
        if (n >= 100) begin fail_count++; end_of_test(); end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        rd_q.push_back(e);
        arvalid <= 1; araddr <= a; rready <= 1; n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 0;
        end while (!(rvalid && rready) && n < 100);
        rready <= 0;
        if (n >= 100) begin fail_count++; end_of_test(); end
    endtask : rd

    task automatic wait_flag(input int bound, input logic e);
        int n;
        n = 0;
        while (flag !== 1'b1 && n < bound) begin
            @(posedge aclk);
            n++;
        end
        check("trip_flag", {33'h0, e}, {33'h0, flag});
        // an expected trip that never came ends the run
        if (e && flag !== 1'b1) end_of_test();
    endtask : wait_flag

    task automatic drive(input logic h, input logic [1:0] p,
                         input logic signed [11:0] l);
        on_hall <= h; phase <= p; level <= l;
    endtask : drive

    task automatic clear_trip;
        drive(0, 0, 0);
        repeat (30) @(posedge aclk);
        wr(8'h00, 32'h1, 2'h0);
        @(posedge aclk);
        check("cleared", '0, {33'h0, flag});
    endtask : clear_trip

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(8'h08, 34'h9);
        rd(8'h0C, 34'h8);
        rd(8'h10, 34'h5);
        rd(8'h14, 34'h0200_0200);
        rd(8'h04, 34'h0);
        rd(8'h40, 34'h2_0000_0000);
        wr(8'h40, 32'h1234_5678, 2'h2);
        drive(0, 0, 12'sd500);
        wait_flag(300, 0);
        drive(0, 0, 12'sd600);
        wait_flag(400, 1);
        rd(8'h04, 34'h5);
        drive(0, 0, 0);
        repeat (40) @(posedge aclk);
        check("latched", 34'h1, {33'h0, flag});
        clear_trip();
        wr(8'h08, 32'h1, 2'h0);
        wr(8'h0C, 32'h4, 2'h0);
        wr(8'h10, 32'h3, 2'h0);
        wr(8'h14, 32'h00C8_0064, 2'h0);
        rd(8'h14, 34'h00C8_0064);
        drive(1, 2, -12'sd150);
        wait_flag(100, 0);
        drive(1, 2, -12'sd250);
        wait_flag(100, 1);
        clear_trip();
        drive(0, 1, 12'sd150);
        wait_flag(100, 1);
        clear_trip();
        wr(8'h10, 32'h8, 2'h0);
        drive(1, 1, 12'sd150);
        wait_flag(100, 0);
        drive(0, 0, 0);
        ext_shutdown <= 1;
        @(posedge aclk);
        ext_shutdown <= 0;
        wait_flag(3, 1);
        rd(8'h04, 34'h3);
        clear_trip();
        rd(8'h04, 34'h0);
        repeat (5) @(posedge aclk);
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
